/* tone_words_cfg.svh */
// Constants for the tone detect and generate word set and its host bridge.
// Operation
// R1 - Off level clears biquad bit; reload -42 dBm
// R2 - On level sets biquad bit; reload -35 dBm
// R3 - Thresholds encoded as ten-power level times 32767
// R4 - Sixteen level words updated in detect mode
// R5 - Discrete bits compared against one global threshold
// R6 - Detect entry reloads -24 dBm; host writes after
// R7 - Flag bit n follows detector n
// R8 - Host ignores flags outside detect mode
// R9 - Standby or reset loads part identity
// R10 - Two scaled generators summed into transmit
// R11 - Zero level word silences its generator
// R12 - Tones sent in mode one, stop at zero
// R13 - Sixteen detectors, one coefficient each, shared threshold
// R14 - Coefficient words consecutive, cosine times 32767
// R15 - Detection runs on 9600 Hz samples
// R16 - Biquad bit holds between off and on
`ifndef TONE_WORDS_CFG_SVH
`define TONE_WORDS_CFG_SVH
`define ADDR_W 9
`define WORD_W 16
`define A_HIT_FLAGS 9'h000
`define A_GLOBAL_THRESH 9'h003
`define A_LEVEL_BASE 9'h026
`define A_BQ_ON 9'h051
`define A_BQ_OFF 9'h052
`define A_COEFF_BASE 9'h145
`define A_MODE 9'h1f0
`define A_GEN_A_COEFF 9'h1f1
`define A_GEN_B_COEFF 9'h1f2
`define A_LOW_LEVEL 9'h1f3
`define A_HIGH_LEVEL 9'h1f4
`define N_DETECTORS 16
`define MODE_STANDBY 16'h0000
`define MODE_TONE_TX 16'h0001
`define MODE_DETECT 16'h0002
`define DEF_BQ_OFF 16'h0104
`define DEF_BQ_ON 16'h0247
`define DEF_GLOBAL_THRESH 16'h0814
// The identity value is arbitrary.
`define PART_ID 16'h5a01
`define CLK_HZ 100000000
`define SAMPLE_HZ 9600
`define SAMPLE_CYCLES (`CLK_HZ / `SAMPLE_HZ)
`define OSC_SEED 16'h4000
`define HR_CMD 8'h00
`define HR_WDATA 8'h04
`define HR_RDATA 8'h08
`define HR_STATUS 8'h0c
`define HR_IRQ_STATUS 8'h10
`define HR_IRQ_MASK 8'h14
`define CMD_WRITE_BIT 16
`endif

/* tone_words_pkg.sv */
// Types shared by the tone word device and its host bridge.
package tone_words_pkg;
   typedef logic [8:0] ram_addr_t;
   typedef logic [15:0] word_t;
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b01,
      SEQ_RUN = 2'b10
   } seq_state_t;
   typedef enum logic [2:0] {
      HB_IDLE = 3'b001,
      HB_STROBE = 3'b010,
      HB_WAIT = 3'b100
   } bridge_state_t;
endpackage : tone_words_pkg

/* tone_ram_if.sv */
// Parallel word port between the host bridge and the tone word device.
interface tone_ram_if;
   import tone_words_pkg::*;
   ram_addr_t addr;
   word_t wdata;
   logic wr;
   logic rd;
   word_t rdata;
   logic ack;
   modport device (input addr, input wdata, input wr, input rd, output rdata, output ack);
   modport host (output addr, output wdata, output wr, output rd, input rdata, input ack);
endinterface : tone_ram_if

/* tone_words_device.sv */
// Tone detector and generator word set with its parallel word port.
`include "tone_words_cfg.svh"
module tone_words_device #(
   parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
   parameter logic [15:0] PART_ID = `PART_ID
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Word port
   tone_ram_if.device ram,
   // Receive and transmit samples
   input wire logic signed [15:0] rx_sample_in,
   output logic signed [15:0] tx_sample_out,
   // Biquad detector status
   output logic tone_a_out,
   output logic tone_b_out
);
   import tone_words_pkg::*;

   localparam int N = `N_DETECTORS;

   word_t mode_reg, hit_flags_reg, thresh_reg, bq_on_reg, bq_off_reg, rdata_reg;
   word_t gen_a_coeff_reg, gen_b_coeff_reg, low_level_reg, high_level_reg;
   word_t pow_a_reg, pow_b_reg, lev_next;
   word_t coeff_reg [N], level_reg [N];
   logic signed [23:0] s1_reg [N], s2_reg [N], s_next;
   logic [15:0] tick_cnt_reg;
   logic [3:0] idx_reg;
   seq_state_t seq_reg;
   logic ack_reg, tick, tone_a_reg, tone_b_reg, mode_wr, detect;
   logic signed [15:0] x_reg, x_prev_reg, tx_reg;
   logic signed [15:0] ya1_reg, ya2_reg, yb1_reg, yb2_reg;

   function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
      if (v > 32'sd32767) begin
         return 16'sh7fff;
      end else if (v < -32'sd32768) begin
         return 16'sh8000;
      end
      return v[15:0];
   endfunction : sat16

   function automatic logic signed [23:0] sat24(input logic signed [39:0] v);
      if (v > 40'sd8388607) begin
         return 24'sh7fffff;
      end else if (v < -40'sd8388607) begin
         return 24'sh800001;
      end
      return v[23:0];
   endfunction : sat24

   // Leaky peak: follow a rise at once, decay by one sixteenth otherwise.
   function automatic word_t leak(input word_t lev, input word_t mag);
      if (mag > lev) begin
         return mag;
      end
      return lev - {4'h0, lev[15:4]};
   endfunction : leak

   // Magnitude clipped to full scale, so that the most negative code cannot exceed it.
   function automatic word_t abs16(input logic signed [15:0] v);
      return (v == 16'sh8000) ? 16'h7fff : (v[15] ? 16'(-v) : 16'(v));
   endfunction : abs16

   // Scale a sample by a Q15 level word; a zero level gives silence.
   function automatic logic signed [31:0] scale(input logic signed [15:0] y, input word_t lev);
      logic signed [31:0] p;
      p = y * $signed({1'b0, lev});
      return p >>> 15;
   endfunction : scale

   function automatic logic signed [15:0] osc(input word_t c, input logic signed [15:0] y1,
                                              input logic signed [15:0] y2);
      logic signed [31:0] p;
      p = ($signed(c) * y1) >>> 14;
      return sat16(p - 32'(y2));
   endfunction : osc

   assign mode_wr = ram.wr && (ram.addr == `A_MODE);
   assign detect = (mode_reg == `MODE_DETECT);
   assign tick = (tick_cnt_reg == 16'(SAMPLE_CYCLES - 1));

   // Word port: one access per strobe, answered on the next edge.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ack_reg <= 1'b0;
         rdata_reg <= 16'h0000;
      end else begin
         ack_reg <= ram.wr || ram.rd;
         if (ram.rd) begin
            rdata_reg <= 16'h0000;
            if (ram.addr == `A_HIT_FLAGS) rdata_reg <= hit_flags_reg;
            if (ram.addr == `A_GLOBAL_THRESH) rdata_reg <= thresh_reg;
            if (ram.addr == `A_BQ_ON) rdata_reg <= bq_on_reg;
            if (ram.addr == `A_BQ_OFF) rdata_reg <= bq_off_reg;
            if (ram.addr == `A_MODE) rdata_reg <= mode_reg;
            if (ram.addr == `A_GEN_A_COEFF) rdata_reg <= gen_a_coeff_reg;
            if (ram.addr == `A_GEN_B_COEFF) rdata_reg <= gen_b_coeff_reg;
            if (ram.addr == `A_LOW_LEVEL) rdata_reg <= low_level_reg;
            if (ram.addr == `A_HIGH_LEVEL) rdata_reg <= high_level_reg;
            for (int i = 0; i < N; i++) begin
               if (ram.addr == `A_LEVEL_BASE + 9'(i)) rdata_reg <= level_reg[i];
               if (ram.addr == `A_COEFF_BASE + 9'(i)) rdata_reg <= coeff_reg[i]; // R14
            end
         end
      end
   end
   assign ram.ack = ack_reg;
   assign ram.rdata = rdata_reg;

   // Host writable words; entering detect mode reloads the thresholds.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_reg <= `MODE_STANDBY;
         thresh_reg <= `DEF_GLOBAL_THRESH;
         bq_on_reg <= `DEF_BQ_ON;
         bq_off_reg <= `DEF_BQ_OFF;
         gen_a_coeff_reg <= 16'h0000;
         gen_b_coeff_reg <= 16'h0000;
         low_level_reg <= 16'h0000;
         high_level_reg <= 16'h0000;
         for (int i = 0; i < N; i++) coeff_reg[i] <= 16'h0000;
      end else if (ram.wr) begin
         if (mode_wr) begin
            mode_reg <= ram.wdata;
            if (ram.wdata == `MODE_DETECT) begin
               thresh_reg <= `DEF_GLOBAL_THRESH; // R6
               bq_on_reg <= `DEF_BQ_ON; // R2
               bq_off_reg <= `DEF_BQ_OFF; // R1
            end
         end
         if (ram.addr == `A_GLOBAL_THRESH) thresh_reg <= ram.wdata;
         if (ram.addr == `A_BQ_ON) bq_on_reg <= ram.wdata;
         if (ram.addr == `A_BQ_OFF) bq_off_reg <= ram.wdata;
         if (ram.addr == `A_GEN_A_COEFF) gen_a_coeff_reg <= ram.wdata;
         if (ram.addr == `A_GEN_B_COEFF) gen_b_coeff_reg <= ram.wdata;
         if (ram.addr == `A_LOW_LEVEL) low_level_reg <= ram.wdata;
         if (ram.addr == `A_HIGH_LEVEL) high_level_reg <= ram.wdata;
         for (int i = 0; i < N; i++) begin
            if (ram.addr == `A_COEFF_BASE + 9'(i)) coeff_reg[i] <= ram.wdata; // R13
         end
      end
   end

   // Sample clock divider.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tick_cnt_reg <= 16'h0000;
      end else if (tick) begin
         tick_cnt_reg <= 16'h0000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 16'h0001; // R15
      end
   end

   // Each sample is run through the sixteen resonators one per cycle.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         seq_reg <= SEQ_IDLE;
         idx_reg <= 4'h0;
         x_reg <= 16'sh0000;
         x_prev_reg <= 16'sh0000;
      end else begin
         case (seq_reg)
            SEQ_IDLE: begin
               if (tick && detect) begin
                  x_prev_reg <= x_reg;
                  x_reg <= rx_sample_in; // R15
                  idx_reg <= 4'h0;
                  seq_reg <= SEQ_RUN;
               end
            end
            SEQ_RUN: begin
               idx_reg <= idx_reg + 4'h1;
               if (idx_reg == 4'(N - 1)) seq_reg <= SEQ_IDLE;
            end
            default: seq_reg <= SEQ_IDLE;
         endcase
      end
   end

   always_comb begin
      logic signed [39:0] fb;
      logic signed [23:0] mag;
      mag = 24'sh000000;
      fb = (40'($signed(coeff_reg[idx_reg])) * 40'(s1_reg[idx_reg])) >>> 14;
      fb = fb + 40'(x_reg) - 40'(s2_reg[idx_reg]);
      fb = fb - (fb >>> 6);
      s_next = sat24(fb);
      mag = (s_next < 0) ? -s_next : s_next;
      lev_next = leak(level_reg[idx_reg], mag[23:8]);
   end

   // Resonator state, level words and hit flags.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hit_flags_reg <= PART_ID; // R9
         for (int i = 0; i < N; i++) begin
            s1_reg[i] <= 24'sh000000;
            s2_reg[i] <= 24'sh000000;
            level_reg[i] <= 16'h0000;
         end
      end else if (mode_wr && ram.wdata == `MODE_STANDBY) begin
         hit_flags_reg <= PART_ID; // R9
      end else if (mode_wr && ram.wdata == `MODE_DETECT) begin
         hit_flags_reg <= 16'h0000;
      end else if (seq_reg == SEQ_RUN) begin
         s2_reg[idx_reg] <= s1_reg[idx_reg];
         s1_reg[idx_reg] <= s_next;
         level_reg[idx_reg] <= lev_next; // R4
         if (lev_next > thresh_reg) begin
            hit_flags_reg[idx_reg] <= 1'b1; // R5 R7 R3
         end else if (lev_next < thresh_reg) begin
            hit_flags_reg[idx_reg] <= 1'b0; // R5 R7
         end
      end
   end

   // Band power estimates with on and off hysteresis.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pow_a_reg <= 16'h0000;
         pow_b_reg <= 16'h0000;
         tone_a_reg <= 1'b0;
         tone_b_reg <= 1'b0;
      end else if (!detect) begin
         tone_a_reg <= 1'b0;
         tone_b_reg <= 1'b0;
      end else if (seq_reg == SEQ_RUN && idx_reg == 4'h0) begin
         pow_a_reg <= leak(pow_a_reg, abs16(x_reg));
         pow_b_reg <= leak(pow_b_reg, abs16(sat16(32'(x_reg) - 32'(x_prev_reg)) >>> 1));
         if (pow_a_reg > bq_on_reg) begin
            tone_a_reg <= 1'b1; // R2 R3
         end else if (pow_a_reg < bq_off_reg) begin
            tone_a_reg <= 1'b0; // R1 R16
         end
         if (pow_b_reg > bq_on_reg) begin
            tone_b_reg <= 1'b1; // R2
         end else if (pow_b_reg < bq_off_reg) begin
            tone_b_reg <= 1'b0; // R1 R16
         end
      end
   end
   assign tone_a_out = tone_a_reg;
   assign tone_b_out = tone_b_reg;

   // Two resonator oscillators, scaled and mixed while mode is transmit tone.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ya1_reg <= `OSC_SEED;
         ya2_reg <= `OSC_SEED;
         yb1_reg <= `OSC_SEED;
         yb2_reg <= `OSC_SEED;
         tx_reg <= 16'sh0000;
      end else if (mode_reg != `MODE_TONE_TX) begin
         ya1_reg <= `OSC_SEED;
         ya2_reg <= `OSC_SEED;
         yb1_reg <= `OSC_SEED;
         yb2_reg <= `OSC_SEED;
         tx_reg <= 16'sh0000; // R12
      end else if (tick) begin
         ya2_reg <= ya1_reg;
         ya1_reg <= osc(gen_a_coeff_reg, ya1_reg, ya2_reg);
         yb2_reg <= yb1_reg;
         yb1_reg <= osc(gen_b_coeff_reg, yb1_reg, yb2_reg);
         tx_reg <= sat16(scale(ya1_reg, low_level_reg) + scale(yb1_reg, high_level_reg)); // R10 R11
      end
   end
   assign tx_sample_out = tx_reg;
endmodule : tone_words_device

/* tone_words_host.sv */
// Host bridge: AHB-Lite registers that drive the tone word port.
`include "tone_words_cfg.svh"
module tone_words_host (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Interrupt
   output logic irq_out,
   // Word port
   tone_ram_if.host ram
);
   import tone_words_pkg::*;

   bridge_state_t st_reg;
   logic dp_wr_reg;
   logic [7:0] dp_addr_reg;
   ram_addr_t cmd_addr_reg;
   logic cmd_write_reg;
   word_t wdata_reg;
   word_t rdata_reg;
   word_t mode_reg;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_mask_reg;
   logic ap_valid;
   logic start;
   logic done;

   assign ap_valid = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign start = dp_wr_reg && dp_addr_reg == `HR_CMD && st_reg == HB_IDLE;
   assign done = st_reg == HB_WAIT && ram.ack;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         dp_wr_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
      end else begin
         dp_wr_reg <= ap_valid && hwrite;
         if (ap_valid) dp_addr_reg <= haddr[7:0];
      end
   end

   // Command word: address in the low bits, write flag above; a write while idle starts it.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cmd_addr_reg <= 9'h000;
         cmd_write_reg <= 1'b0;
         wdata_reg <= 16'h0000;
         irq_mask_reg <= 2'h0;
      end else if (dp_wr_reg) begin
         if (start) begin
            cmd_addr_reg <= hwdata[8:0];
            cmd_write_reg <= hwdata[`CMD_WRITE_BIT];
         end
         if (dp_addr_reg == `HR_WDATA) wdata_reg <= hwdata[15:0]; // R3 R11
         if (dp_addr_reg == `HR_IRQ_MASK) irq_mask_reg <= hwdata[1:0];
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg <= HB_IDLE;
         rdata_reg <= 16'h0000;
         mode_reg <= `MODE_STANDBY;
      end else begin
         case (st_reg)
            HB_IDLE: if (start) st_reg <= HB_STROBE;
            HB_STROBE: begin
               st_reg <= HB_WAIT;
               if (cmd_write_reg && cmd_addr_reg == `A_MODE) begin
                  mode_reg <= wdata_reg; // R12 R6
               end
            end
            HB_WAIT: begin
               if (ram.ack) begin
                  st_reg <= HB_IDLE;
                  if (!cmd_write_reg) rdata_reg <= ram.rdata;
               end
            end
            default: st_reg <= HB_IDLE;
         endcase
      end
   end

   assign ram.addr = cmd_addr_reg;
   assign ram.wdata = wdata_reg;
   assign ram.wr = st_reg == HB_STROBE && cmd_write_reg;
   assign ram.rd = st_reg == HB_STROBE && !cmd_write_reg;

   // Bit 0 done, bit 1 done of a hit flag read while flags were not valid; set wins over clear.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_stat_reg <= 2'h0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~((dp_wr_reg && dp_addr_reg == `HR_IRQ_STATUS) ?
                          hwdata[1:0] : 2'h0)) |
                         {done && !cmd_write_reg && cmd_addr_reg == `A_HIT_FLAGS &&
                          mode_reg != `MODE_DETECT, done}; // R8
      end
   end
   assign irq_out = |(irq_stat_reg & irq_mask_reg);

   always_comb begin
      case (dp_addr_reg)
         `HR_CMD: hrdata = {15'h0000, cmd_write_reg, 7'h00, cmd_addr_reg};
         `HR_WDATA: hrdata = {16'h0000, wdata_reg};
         `HR_RDATA: hrdata = {16'h0000, rdata_reg};
         `HR_STATUS: hrdata = {30'h00000000, mode_reg == `MODE_DETECT, st_reg != HB_IDLE}; // R8
         `HR_IRQ_STATUS: hrdata = {30'h00000000, irq_stat_reg};
         `HR_IRQ_MASK: hrdata = {30'h00000000, irq_mask_reg};
         default: hrdata = 32'h00000000;
      endcase
   end
endmodule : tone_words_host

/* tone_ram_assertions.sv */
// Checker for the word port joining the host bridge and the tone word device.
module tone_ram_assertions #(
   // The identity value is arbitrary.
   parameter logic [15:0] PART_ID = 16'h5a01
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Word port
   input wire tone_words_pkg::ram_addr_t addr,
   input wire tone_words_pkg::word_t wdata,
   input wire logic wr,
   input wire logic rd,
   input wire tone_words_pkg::word_t rdata,
   input wire logic ack
);
   import tone_words_pkg::*;
   word_t mode_reg;
   logic [2:0] fresh_reg;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         mode_reg <= 16'h0000;
      else if (wr && addr == 9'h1f0)
         mode_reg <= wdata;
   end
   // A threshold word stays fresh until a host write replaces its reloaded default.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         fresh_reg <= 3'b111;
      else if (wr && addr == 9'h1f0 && wdata == 16'h0002)
         fresh_reg <= 3'b111;
      else if (wr)
         fresh_reg <= fresh_reg & ~{addr == 9'h052, addr == 9'h051, addr == 9'h003};
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);
   sequence s_strobe;
      wr || rd;
   endsequence
   sequence s_answer;
      ack ##1 !ack;
   endsequence
   property p_reads(a, v, f);
      rd && addr == a && f |=> rdata == v;
   endproperty
   a_ack_answer: assert property (s_strobe |=> s_answer)
      else $error("Word port ack missing or too long.");
   a_ack_cause: assert property (ack |-> $past(wr || rd))
      else $error("Word port ack without a strobe.");
   a_strobe_excl: assert property (!(wr && rd))
      else $error("Read and write strobes together.");
   a_strobe_single: assert property (s_strobe |=> !wr && !rd)
      else $error("Strobe longer than one cycle.");
   a_rdata_hold: assert property (!rd |=> $stable(rdata))
      else $error("Read data moved without a read.");
   a_hit_ident: assert property (p_reads(9'h000, PART_ID, mode_reg == 16'h0000))
      else $error("Hit flags lack identity in standby.");
   a_thr_reload: assert property (p_reads(9'h003, 16'h0814, fresh_reg[0]))
      else $error("Global threshold default wrong.");
   a_on_reload: assert property (p_reads(9'h051, 16'h0247, fresh_reg[1]))
      else $error("On level default wrong.");
   a_off_reload: assert property (p_reads(9'h052, 16'h0104, fresh_reg[2]))
      else $error("Off level default wrong.");
endmodule : tone_ram_assertions

/* tb.sv */
// Testbench joining both ends of the tone word port over AHB-Lite.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tone_words_pkg::*;
   localparam int SC = 32;
   localparam logic [15:0] ID = 16'h5a01; // Arbitrary identity value.
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, r;
   logic hreadyout, irq_out, tone_a, tone_b, noise, nz;
   logic signed [15:0] rx = 16'sh0;
   logic signed [15:0] tx;
   int bad_count = 0;
   int check_count = 0;
   word_t cw[16];
   ram_addr_t ta[3] = '{9'h003, 9'h051, 9'h052};
   // Encoded defaults: -24 dBm global threshold, -35 dBm on level, -42 dBm off level.
   function automatic word_t exp_default(input ram_addr_t a);
      return (a == 9'h003) ? 16'h0814 : ((a == 9'h051) ? 16'h0247 : 16'h0104);
   endfunction : exp_default
   tone_ram_if ram_if ();
   tone_words_device #(.SAMPLE_CYCLES(SC), .PART_ID(ID)) tone_words_device_inst (
      .clk_in(clk_in), .nrst_in(nrst_in), .ram(ram_if.device), .rx_sample_in(rx),
      .tx_sample_out(tx), .tone_a_out(tone_a), .tone_b_out(tone_b));
   tone_words_host tone_words_host_inst (
      .clk_in(clk_in), .nrst_in(nrst_in), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .irq_out(irq_out), .ram(ram_if.host));
   tone_ram_assertions #(.PART_ID(ID)) tone_ram_assertions_inst (
      .clk_in(clk_in), .nrst_in(nrst_in), .addr(ram_if.addr), .wdata(ram_if.wdata),
      .wr(ram_if.wr), .rd(ram_if.rd), .rdata(ram_if.rdata), .ack(ram_if.ack));
   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      rx <= noise ? 16'($urandom) : 16'sh0000;
      if (tx !== 16'sh0)
         nz <= 1'b1;
   end
   task report_and_stop;
      $display("Checks %0d, errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   task fail(input string m);
      bad_count++;
      $display("ERROR %0t %s", $time, m);
      report_and_stop;
   endtask : fail
   task chk(input word_t got, input word_t exp, input string m);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t %s got %h expected %h", $time, m, got, exp);
      end
   endtask : chk
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do begin @(posedge clk_in); n++; end while (hreadyout !== 1'b1 && n < 40);
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge clk_in); n++; end while (hreadyout !== 1'b1 && n < 80);
      r = hrdata;
      if (n >= 80)
         fail("bus answer timeout");
   endtask : ahb
   // Indirect word access: data if a write, command, busy poll, then read data if a read.
   task word(input logic w, input ram_addr_t a, input word_t d);
      int n;
      n = 0;
      if (w)
         ahb(1'b1, 8'h04, {16'h0, d});
      ahb(1'b1, 8'h00, {15'h0, w, 7'h0, a});
      do begin ahb(1'b0, 8'h0c, 32'h0); n++; end while (r[0] !== 1'b0 && n < 20);
      if (n >= 20)
         fail("word access timeout");
      if (!w)
         ahb(1'b0, 8'h08, 32'h0);
   endtask : word
   task ticks(input int k);
      repeat (k * SC) @(posedge clk_in);
   endtask : ticks
   initial begin
      noise = 1'b0;
      nz = 1'b0;
      void'($urandom(81));
      repeat (6) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      word(1'b0, 9'h000, 16'h0);
      chk(r[15:0], ID, "identity after reset");
      for (int i = 0; i < 3; i++) begin
         word(1'b0, ta[i], 16'h0);
         chk(r[15:0], exp_default(ta[i]), "default level");
      end
      ahb(1'b1, 8'h14, 32'h3);
      ahb(1'b0, 8'h10, 32'h0);
      chk(r[15:0], 16'h0003, "done and stale flag events");
      chk({15'h0, irq_out}, 16'h0001, "interrupt raised");
      ahb(1'b1, 8'h14, 32'h0);
      ahb(1'b1, 8'h10, 32'h3);
      ahb(1'b0, 8'h10, 32'h0);
      chk(r[15:0], 16'h0000, "events cleared");
      chk({15'h0, irq_out}, 16'h0000, "interrupt masked and cleared");
      ahb(1'b0, 8'h18, 32'h0);
      chk(r[15:0], 16'h0000, "unmapped offset");
      for (int i = 0; i < 3; i++) begin
         word(1'b1, ta[i], 16'h0100 + 16'($urandom % 16'h7000));
         word(1'b1, 9'h1f0, 16'h0002);
         word(1'b0, ta[i], 16'h0);
         chk(r[15:0], exp_default(ta[i]), "reload on detect entry");
      end
      ahb(1'b0, 8'h0c, 32'h0);
      chk({15'h0, r[1]}, 16'h0001, "flags valid in detect");
      for (int i = 0; i < 16; i++) begin
         cw[i] = 16'($urandom);
         word(1'b1, 9'h145 + 9'(i), cw[i]);
      end
      for (int i = 0; i < 16; i++) begin
         word(1'b0, 9'h145 + 9'(i), 16'h0);
         chk(r[15:0], cw[i], "coefficient word");
      end
      word(1'b1, 9'h003, 16'h7fff);
      ticks(3);
      word(1'b0, 9'h000, 16'h0);
      chk(r[15:0], 16'h0000, "no tone below threshold");
      word(1'b1, 9'h003, 16'h0000);
      noise = 1'b1;
      ticks(40);
      word(1'b0, 9'h000, 16'h0);
      chk(r[15:0], 16'hffff, "every detector above zero");
      for (int i = 0; i < 16; i++) begin
         word(1'b0, 9'h026 + 9'(i), 16'h0);
         chk({15'h0, r[15:0] == 16'h0}, 16'h0000, "level word updated");
      end
      word(1'b1, 9'h003, 16'h7fff);
      ticks(4);
      word(1'b0, 9'h000, 16'h0);
      chk(r[15:0], 16'h0000, "bits cleared below threshold");
      chk({14'h0, tone_a, tone_b}, 16'h0003, "band bits on above on level");
      word(1'b1, 9'h052, 16'h0000);
      word(1'b1, 9'h051, 16'h7fff);
      noise = 1'b0;
      ticks(90);
      chk({14'h0, tone_a, tone_b}, 16'h0003, "band bits held between levels");
      word(1'b1, 9'h052, 16'h0104);
      ticks(2);
      chk({14'h0, tone_a, tone_b}, 16'h0000, "band bits off below off level");
      word(1'b1, 9'h1f0, 16'h0000);
      word(1'b0, 9'h000, 16'h0);
      chk(r[15:0], ID, "identity in standby");
      chk({14'h0, tone_a, tone_b}, 16'h0000, "band bits off outside detect");
      word(1'b1, 9'h1f1, 16'h4000);
      word(1'b1, 9'h1f2, 16'h2000);
      word(1'b1, 9'h1f3, 16'h0000);
      word(1'b1, 9'h1f4, 16'h0000);
      word(1'b1, 9'h1f0, 16'h0001);
      nz = 1'b0;
      ticks(10);
      chk({15'h0, nz}, 16'h0000, "silent at zero levels");
      word(1'b1, 9'h1f3, 16'h1000);
      ticks(10);
      chk({15'h0, nz}, 16'h0001, "tone transmitted");
      word(1'b1, 9'h1f0, 16'h0000);
      ticks(2);
      chk(tx, 16'h0000, "tone stops in standby");
      report_and_stop;
   end
endmodule : tb
